// [fcl_pkg.sv]
/*
 * Shared constants and carrier types for the fuse configuration latch.
 * Assumes a single 40 MHz clock and a synchronous active-low reset.
 */
package fcl_pkg;

  // ==========================================================
  // Action select and command codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_ID    = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  // ==========================================================
  // Fuse field positions (0 = programmed)
  localparam int HI_EXT_RST_DIS   = 7;
  localparam int HI_DEBUG_EN      = 6;
  localparam int HI_SERIAL_DL_EN  = 5;
  localparam int HI_WDOG_ON       = 4;
  localparam int HI_EE_PRESERVE   = 3;
  localparam int HI_BROWNOUT_LSB  = 0;
  localparam int LO_CLK_DIV8      = 7;
  localparam int LO_CLK_OUT       = 6;
  localparam int LO_STARTUP_LSB   = 4;
  localparam int LO_CLK_SRC_LSB   = 0;
  localparam int EX_GRP2_FORCE    = 7;
  localparam int EX_GRP1_FORCE    = 6;
  localparam int EX_GRP0_FORCE    = 5;
  localparam int EX_OUT_LEVEL     = 4;

  localparam logic [7:0] HI_DEF   = 8'hDF;
  localparam logic [7:0] LO_DEF   = 8'h62;
  localparam logic [7:0] EXT_DEF  = 8'hF9;
  localparam logic [7:0] LOCK_DEF = 8'hFF;
  localparam logic [7:0] BLANK    = 8'hFF;

  // ==========================================================
  // Identification space and byte selects
  localparam logic [7:0] ID_ADDR_MAKER = 8'h00;
  localparam logic [7:0] ID_ADDR_SIZE  = 8'h01;
  localparam logic [7:0] ID_ADDR_VAR   = 8'h02;
  localparam logic [1:0] FSEL_LO   = 2'h0;
  localparam logic [1:0] FSEL_LOCK = 2'h1;
  localparam logic [1:0] FSEL_EXT  = 2'h2;
  localparam logic [1:0] FSEL_HI   = 2'h3;
  localparam logic [1:0] SER_LO  = 2'h0;
  localparam logic [1:0] SER_HI  = 2'h1;
  localparam logic [1:0] SER_EXT = 2'h2;
  localparam logic [1:0] SER_ID  = 2'h3;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_MIN_NS  = 250;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Carriers and state
  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] hi;
    logic [7:0] lo;
  } fcl_fuse_t;

  typedef struct packed {
    logic       req;
    logic       wr;
    logic [1:0] sel;
    logic [7:0] addr;
    logic [7:0] data;
  } fcl_ser_req_t;

  typedef struct packed {
    logic       held;
    logic [3:0] cfg;
    logic [3:0] pins;
  } fcl_grp_st_t;

  typedef struct packed {
    logic        osc_prev;
    logic        wr_prev;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  dat;
    logic        wr_stb;
  } fcl_pp_st_t;

  typedef struct packed {
    logic       powered;
    logic       prog_prev;
    fcl_fuse_t  stored;
    fcl_fuse_t  act;
    logic [7:0] lock;
    logic [3:0] busy;
    logic       rdy;
    logic [7:0] osc_calibration_reg;
    logic [7:0] dout;
    logic       dout_oe_n;
    logic [7:0] ser_rdata;
  } fcl_top_st_t;

endpackage

// [fcl_out_group.sv]
/*
 * One group of stage-controller outputs with reset forcing.
 * Assumes fuse inputs are the latched copies and stable during reset.
 */
`timescale 1ns/1ps
`default_nettype none
module fcl_out_group
#(
  parameter int N = 2
)
(
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         core_rst_in,
  input  wire logic         force_fuse_in,
  input  wire logic         level_in,
  input  wire logic         wr_in,
  input  wire logic [N-1:0] wdata_in,
  input  wire logic [N-1:0] port_in,
  input  wire logic [N-1:0] stage_in,
  output var  logic [N-1:0] pin_out
);

  fcl_pkg::fcl_grp_st_t st;
  fcl_pkg::fcl_grp_st_t next_st;
  logic [3:0]           port4;
  logic [3:0]           stage4;

  // ==========================================================
  // Force and release
  always_comb
  begin
    next_st = st;
    port4 = '0;
    stage4 = '0;
    port4[N-1:0] = port_in;
    stage4[N-1:0] = stage_in;
    if (core_rst_in)
    begin
      next_st.held = !force_fuse_in;
      next_st.cfg = '0;
    end
    else if (wr_in)
    begin
      next_st.held = 1'b0;
      next_st.cfg[N-1:0] = wdata_in;
    end
    // Enabled bits take the stage drive, others the port value
    next_st.pins = next_st.held ? {4{level_in}} : ((next_st.cfg & stage4) | (~next_st.cfg & port4));
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign pin_out = st.pins[N-1:0];

  // ==========================================================
  // Checks
  default clocking chk_clk @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  chk_force_level: assert property (
    core_rst_in && !force_fuse_in |=> pin_out == {N{$past(level_in)}})
    else $error("forced group not at reset level");
  chk_plain_port: assert property (
    core_rst_in && force_fuse_in && !wr_in |=> !st.held ##0 pin_out == $past(port_in))
    else $error("unforced group not following port");
  chk_release_write: assert property (
    st.held && wr_in && !core_rst_in |=> !st.held ##0 st.cfg[N-1:0] == $past(wdata_in))
    else $error("group not released by config write");

endmodule
`default_nettype wire

// [fcl_prog_port.sv]
/*
 * Parallel programming front end: action loads and write strobe.
 * Assumes programmer pins are synchronous and pulses span several clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module fcl_prog_port
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        prog_in,
  input  wire logic        osc_in,
  input  wire logic        action_select_hi_in,
  input  wire logic        action_select_lo_in,
  input  wire logic        byte_sel1_in,
  input  wire logic        wr_n_in,
  input  wire logic [7:0]  data_in,
  output var  logic [7:0]  cmd_out,
  output var  logic [15:0] addr_out,
  output var  logic [7:0]  dat_out,
  output var  logic        wr_stb_out
);

  fcl_pkg::fcl_pp_st_t st;
  fcl_pkg::fcl_pp_st_t next_st;

  // ==========================================================
  // Loads on oscillator pin rise
  always_comb
  begin
    next_st = st;
    next_st.osc_prev = osc_in;
    next_st.wr_prev = wr_n_in;
    next_st.wr_stb = prog_in && st.wr_prev && !wr_n_in;
    if (prog_in && osc_in && !st.osc_prev)
    begin
      unique case ({action_select_hi_in, action_select_lo_in})
        fcl_pkg::ACT_ADDR:
          if (byte_sel1_in)
            next_st.addr[15:8] = data_in;
          else
            next_st.addr[7:0] = data_in;
        fcl_pkg::ACT_DATA: next_st.dat = data_in;
        fcl_pkg::ACT_CMD:  next_st.cmd = data_in;
        fcl_pkg::ACT_IDLE: ;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      st <= '{osc_prev: 1'b0, wr_prev: 1'b1, cmd: 8'h00, addr: 16'h0000, dat: 8'h00, wr_stb: 1'b0};
    else
      st <= next_st;
  end

  assign cmd_out = st.cmd;
  assign addr_out = st.addr;
  assign dat_out = st.dat;
  assign wr_stb_out = st.wr_stb;

  // ==========================================================
  // Checks
  default clocking chk_clk @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  chk_cmd_load: assert property (
    prog_in && osc_in && !st.osc_prev && action_select_hi_in && !action_select_lo_in
      |=> cmd_out == $past(data_in))
    else $error("command byte not loaded");
  chk_idle_action: assert property (
    action_select_hi_in && action_select_lo_in |=> $stable(cmd_out) && $stable(dat_out) && $stable(addr_out))
    else $error("idle action changed a load register");

endmodule
`default_nettype wire

// [fcl_top.sv]
/*
 * Fuse configuration latch, identification bytes and output forcing.
 * Assumes the programmer and the core share clk_in; pins are synchronous.
 */
// Functional notes
// - Reset level fuse selects forced output level
// - Group0 fuse forces outputs until config write
// - Group1 fuse forces outputs until config write
// - Group2 fuse forces four outputs until written
// - High fuse byte field layout
// - Low fuse byte field layout
// - Serial path cannot touch serial enable fuse
// - Chip erase keeps all fuses
// - Lock bit 0 programmed (zero) blocks fuse writes
// - Fuses latched on programming entry, deferred
// - EEPROM preserve fuse acts immediately
// - Fuses latched at power-up
// - Three identification bytes, readable when locked
// - Maker, size, variant identification meaning
// - Calibration byte copied at every reset
// - Oscillator pin pulse performs selected action
// - Write strobe executes last loaded command
// - Action select coding
// - Command byte decoding
// - Programmed fuse reads zero; the serial high-byte read returns the serial enable bit as one
// - Extended fuse byte field layout
`timescale 1ns/1ps
`default_nettype none
module fcl_top
#(
  parameter logic [7:0] ID_MAKER = 8'h5A, // Arbitrary value
  parameter logic [7:0] ID_SIZE  = 8'h42, // Arbitrary value
  parameter logic [7:0] ID_VAR   = 8'h07, // Arbitrary value
  parameter logic [7:0] CAL_BYTE = 8'h80,
  parameter logic [3:0] BUSY_CYC = 4'h8
)
(
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  input  wire logic                 core_rst_in,
  input  wire logic                 prog_mode_in,
  input  wire logic                 oscillator_input_pin_in,
  input  wire logic                 action_select_hi_in,
  input  wire logic                 action_select_lo_in,
  input  wire logic                 byte_sel1_in,
  input  wire logic                 byte_sel2_in,
  input  wire logic                 wr_n_in,
  input  wire logic                 oe_n_in,
  input  wire logic [7:0]           data_in,
  input  wire fcl_pkg::fcl_ser_req_t ser_in,
  input  wire logic                 osc_calibration_reg_wr_in,
  input  wire logic [7:0]           osc_calibration_reg_data_in,
  input  wire logic [2:0]           grp_cfg_wr_in,
  input  wire logic [3:0]           grp_cfg_data_in,
  input  wire logic [7:0]           port_val_in,
  input  wire logic [7:0]           stage_drive_in,
  output var  logic [7:0]           data_out,
  output var  logic                 data_oe_n_out,
  output var  logic                 rdy_out,
  output var  logic [7:0]           ser_rdata_out,
  output var  fcl_pkg::fcl_fuse_t   fuse_cfg_out,
  output var  logic [7:0]           lock_out,
  output var  logic [7:0]           osc_calibration_reg_out,
  output var  logic                 group0_out_a_out,
  output var  logic                 group0_out_b_out,
  output var  logic                 group1_out_a_out,
  output var  logic                 group1_out_b_out,
  output var  logic                 group2_out_a_out,
  output var  logic                 group2_out_b_out,
  output var  logic                 group2_out_c_out,
  output var  logic                 group2_out_d_out
);

  localparam fcl_pkg::fcl_fuse_t FUSE_DEF = '{ext: fcl_pkg::EXT_DEF, hi: fcl_pkg::HI_DEF, lo: fcl_pkg::LO_DEF};
  localparam fcl_pkg::fcl_top_st_t ST_RST = '{
    powered: 1'b0, prog_prev: 1'b0, stored: FUSE_DEF, act: FUSE_DEF,
    lock: fcl_pkg::LOCK_DEF, busy: 4'h0, rdy: 1'b1, osc_calibration_reg: CAL_BYTE,
    dout: fcl_pkg::BLANK, dout_oe_n: 1'b1, ser_rdata: 8'h00};

  fcl_pkg::fcl_top_st_t st;
  fcl_pkg::fcl_top_st_t next_st;
  logic [7:0]           pp_cmd;
  logic [15:0]          pp_addr;
  logic [7:0]           pp_dat;
  logic                 pp_wr_stb;
  logic [1:0]           g0_pins;
  logic [1:0]           g1_pins;
  logic [3:0]           g2_pins;

  // ==========================================================
  // Helpers
  function automatic logic fuse_writable(input logic [7:0] lock);
    fuse_writable = lock[0];
  endfunction

  function automatic logic [7:0] ident_byte(input logic [7:0] addr);
    unique case (addr)
      fcl_pkg::ID_ADDR_MAKER: ident_byte = ID_MAKER;
      fcl_pkg::ID_ADDR_SIZE:  ident_byte = ID_SIZE;
      fcl_pkg::ID_ADDR_VAR:   ident_byte = ID_VAR;
      default:                ident_byte = fcl_pkg::BLANK;
    endcase
  endfunction

  function automatic logic [7:0] fuse_byte(input logic [1:0] sel,
                                           input fcl_pkg::fcl_fuse_t f,
                                           input logic [7:0] lock);
    unique case (sel)
      fcl_pkg::FSEL_LO:   fuse_byte = f.lo;
      fcl_pkg::FSEL_LOCK: fuse_byte = lock;
      fcl_pkg::FSEL_EXT:  fuse_byte = f.ext;
      fcl_pkg::FSEL_HI:   fuse_byte = f.hi;
    endcase
  endfunction

  // ==========================================================
  // Parallel pin front end
  fcl_prog_port u_prog_port (
    .clk_in              (clk_in),
    .nrst_in             (nrst_in),
    .prog_in             (prog_mode_in),
    .osc_in              (oscillator_input_pin_in),
    .action_select_hi_in (action_select_hi_in),
    .action_select_lo_in (action_select_lo_in),
    .byte_sel1_in        (byte_sel1_in),
    .wr_n_in             (wr_n_in),
    .data_in             (data_in),
    .cmd_out             (pp_cmd),
    .addr_out            (pp_addr),
    .dat_out             (pp_dat),
    .wr_stb_out          (pp_wr_stb)
  );

  // ==========================================================
  // Fuse store, commands and reads
  always_comb
  begin
    next_st = st;
    next_st.powered = 1'b1;
    next_st.prog_prev = prog_mode_in;
    if (st.busy != 4'h0)
      next_st.busy = st.busy - 4'h1;

    // Capture at power-up and at either mode edge; held in between, except the preserve bit, which follows stored every cycle
    if (!st.powered)
      next_st.act = st.stored;
    else if (prog_mode_in != st.prog_prev)
      next_st.act = st.stored;
    next_st.act.hi[fcl_pkg::HI_EE_PRESERVE] = st.stored.hi[fcl_pkg::HI_EE_PRESERVE];

    // Commands refused while busy; the programmer waits on ready
    if (prog_mode_in && pp_wr_stb && st.busy == 4'h0)
    begin
      unique case (pp_cmd)
        fcl_pkg::CMD_ERASE:
        begin
          next_st.lock = fcl_pkg::LOCK_DEF;
          next_st.busy = BUSY_CYC;
        end
        fcl_pkg::CMD_WR_FUSE:
          if (fuse_writable(st.lock))
          begin
            unique case ({byte_sel2_in, byte_sel1_in})
              fcl_pkg::FSEL_LO:  next_st.stored.lo = pp_dat;
              fcl_pkg::FSEL_HI:  next_st.stored.hi = pp_dat;
              fcl_pkg::FSEL_EXT: next_st.stored.ext = pp_dat;
              default: ;
            endcase
            next_st.busy = BUSY_CYC;
          end
        fcl_pkg::CMD_WR_LOCK:
        begin
          // Lock bits only go towards programmed here
          next_st.lock = st.lock & pp_dat;
          next_st.busy = BUSY_CYC;
        end
        fcl_pkg::CMD_WR_FLASH, fcl_pkg::CMD_WR_EE:
          next_st.busy = BUSY_CYC;
        default: ;
      endcase
    end

    // Serial path
    if (prog_mode_in && ser_in.req)
    begin
      if (ser_in.wr && fuse_writable(st.lock))
      begin
        unique case (ser_in.sel)
          fcl_pkg::SER_LO:  next_st.stored.lo = ser_in.data;
          fcl_pkg::SER_HI:
          begin
            next_st.stored.hi = ser_in.data;
            next_st.stored.hi[fcl_pkg::HI_SERIAL_DL_EN] = st.stored.hi[fcl_pkg::HI_SERIAL_DL_EN];
          end
          fcl_pkg::SER_EXT: next_st.stored.ext = ser_in.data;
          fcl_pkg::SER_ID:  ;
        endcase
      end
      unique case (ser_in.sel)
        fcl_pkg::SER_LO:  next_st.ser_rdata = st.stored.lo;
        fcl_pkg::SER_HI:
        begin
          next_st.ser_rdata = st.stored.hi;
          next_st.ser_rdata[fcl_pkg::HI_SERIAL_DL_EN] = 1'b1;
        end
        fcl_pkg::SER_EXT: next_st.ser_rdata = st.stored.ext;
        fcl_pkg::SER_ID:  next_st.ser_rdata = ident_byte(ser_in.addr);
      endcase
    end

    // Parallel read, readable regardless of lock state
    next_st.dout_oe_n = !(prog_mode_in && !oe_n_in);
    unique case (pp_cmd)
      fcl_pkg::CMD_RD_ID:
        next_st.dout = byte_sel1_in ? CAL_BYTE : ident_byte(pp_addr[7:0]);
      fcl_pkg::CMD_RD_FUSE:
        next_st.dout = fuse_byte({byte_sel2_in, byte_sel1_in}, st.stored, st.lock);
      default:
        next_st.dout = fcl_pkg::BLANK;
    endcase

    // Calibration copy wins over core writes during reset
    if (core_rst_in)
      next_st.osc_calibration_reg = CAL_BYTE;
    else if (osc_calibration_reg_wr_in)
      next_st.osc_calibration_reg = osc_calibration_reg_data_in;

    next_st.rdy = (next_st.busy == 4'h0);
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      st <= ST_RST;
    else
      st <= next_st;
  end

  // ==========================================================
  // Output groups
  fcl_out_group #(.N(2)) u_group0 (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .core_rst_in   (core_rst_in),
    .force_fuse_in (st.act.ext[fcl_pkg::EX_GRP0_FORCE]),
    .level_in      (st.act.ext[fcl_pkg::EX_OUT_LEVEL]),
    .wr_in         (grp_cfg_wr_in[0]),
    .wdata_in      (grp_cfg_data_in[1:0]),
    .port_in       (port_val_in[1:0]),
    .stage_in      (stage_drive_in[1:0]),
    .pin_out       (g0_pins)
  );

  fcl_out_group #(.N(2)) u_group1 (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .core_rst_in   (core_rst_in),
    .force_fuse_in (st.act.ext[fcl_pkg::EX_GRP1_FORCE]),
    .level_in      (st.act.ext[fcl_pkg::EX_OUT_LEVEL]),
    .wr_in         (grp_cfg_wr_in[1]),
    .wdata_in      (grp_cfg_data_in[1:0]),
    .port_in       (port_val_in[3:2]),
    .stage_in      (stage_drive_in[3:2]),
    .pin_out       (g1_pins)
  );

  fcl_out_group #(.N(4)) u_group2 (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .core_rst_in   (core_rst_in),
    .force_fuse_in (st.act.ext[fcl_pkg::EX_GRP2_FORCE]),
    .level_in      (st.act.ext[fcl_pkg::EX_OUT_LEVEL]),
    .wr_in         (grp_cfg_wr_in[2]),
    .wdata_in      (grp_cfg_data_in),
    .port_in       (port_val_in[7:4]),
    .stage_in      (stage_drive_in[7:4]),
    .pin_out       (g2_pins)
  );

  assign group0_out_a_out = g0_pins[0];
  assign group0_out_b_out = g0_pins[1];
  assign group1_out_a_out = g1_pins[0];
  assign group1_out_b_out = g1_pins[1];
  assign group2_out_a_out = g2_pins[0];
  assign group2_out_b_out = g2_pins[1];
  assign group2_out_c_out = g2_pins[2];
  assign group2_out_d_out = g2_pins[3];

  assign data_out = st.dout;
  assign data_oe_n_out = st.dout_oe_n;
  assign rdy_out = st.rdy;
  assign ser_rdata_out = st.ser_rdata;
  assign fuse_cfg_out = st.act;
  assign lock_out = st.lock;
  assign osc_calibration_reg_out = st.osc_calibration_reg;

  // ==========================================================
  // Checks
  default clocking chk_clk @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence erase_taken;
    prog_mode_in && pp_wr_stb && pp_cmd == fcl_pkg::CMD_ERASE && st.busy == 4'h0 && !ser_in.req;
  endsequence

  sequence fuse_write_taken;
    prog_mode_in && pp_wr_stb && pp_cmd == fcl_pkg::CMD_WR_FUSE && st.busy == 4'h0 && !ser_in.req;
  endsequence

  chk_erase_keeps: assert property (
    erase_taken |=> $stable(st.stored) && st.lock == fcl_pkg::LOCK_DEF && !rdy_out)
    else $error("chip erase altered fuses or kept locks");
  chk_lock_blocks: assert property (
    !st.lock[0] |=> $stable(st.stored))
    else $error("fuse written while locked");
  chk_fuse_write: assert property (
    fuse_write_taken and (st.lock[0] && !byte_sel2_in && !byte_sel1_in)
      |=> st.stored.lo == $past(pp_dat) ##1 !rdy_out)
    else $error("low fuse write not executed");
  chk_serial_protect: assert property (
    prog_mode_in && ser_in.req && ser_in.wr && ser_in.sel == fcl_pkg::SER_HI && !pp_wr_stb
      |=> st.stored.hi[fcl_pkg::HI_SERIAL_DL_EN] == $past(st.stored.hi[fcl_pkg::HI_SERIAL_DL_EN]))
    else $error("serial path changed serial enable fuse");
  chk_defer_latch: assert property (
    prog_mode_in && st.prog_prev |=> $stable(st.act.lo) && $stable(st.act.ext))
    else $error("latched fuses changed inside programming mode");
  chk_eeprom_preserve_fuse_live: assert property (
    $changed(st.stored.hi) |=> fuse_cfg_out.hi[fcl_pkg::HI_EE_PRESERVE] == $past(st.stored.hi[fcl_pkg::HI_EE_PRESERVE]))
    else $error("preserve fuse not taken at once");
  chk_powerup_latch: assert property (
    !st.powered |=> fuse_cfg_out == $past(st.stored))
    else $error("fuses not latched at power-up");
  chk_ident_read: assert property (
    prog_mode_in && !oe_n_in && pp_cmd == fcl_pkg::CMD_RD_ID && !byte_sel1_in && pp_addr[7:0] == fcl_pkg::ID_ADDR_SIZE
      |=> data_out == ID_SIZE && !data_oe_n_out)
    else $error("identification byte misread");
  chk_cal_copy: assert property (
    core_rst_in [*2] |-> osc_calibration_reg_out == CAL_BYTE)
    else $error("calibration not copied during reset");

endmodule
`default_nettype wire

// [fcl_prog_model.sv]
/* Parallel programmer model: drives action, strobe and data pins.
   Assumes the device samples its pins on rising clk_in edges. */
`timescale 1ns/1ps
`default_nettype none
module fcl_prog_model
(
  input  wire logic       clk_in,
  output var  logic       osc_out,
  output var  logic [1:0] act_out,
  output var  logic       wr_n_out,
  output var  logic       oe_n_out,
  output var  logic [7:0] data_out
);
  initial {osc_out, act_out, wr_n_out, oe_n_out, data_out} = 13'h0FFF;
  // ==========
  // Pulse helpers
  task automatic hold();
    repeat (fcl_pkg::PULSE_MIN_CYC) @(posedge clk_in);
    #2;
  endtask
  task automatic load(input logic [1:0] a, input logic [7:0] d);
    act_out = a;
    data_out = d;
    osc_out = 1'b1;
    hold();
    osc_out = 1'b0;
    hold();
    act_out = fcl_pkg::ACT_IDLE;
    data_out = ~d; // Released bus must not keep the old byte
    @(posedge clk_in);
    #2;
  endtask
  task automatic strobe();
    wr_n_out = 1'b0;
    hold();
    wr_n_out = 1'b1;
    hold();
  endtask
  task automatic oe(input logic v);
    oe_n_out = v;
    hold();
  endtask
endmodule
`default_nettype wire

// [fcl_top_tb.sv]
/* Self-checking bench for fcl_top with an integer reference model.
   Assumes fcl_prog_model plays the parallel programmer. */
`timescale 1ns/1ps
`default_nettype none
module fcl_top_tb;
  logic clk_in = 1'b0, nrst_in = 1'b0, core_rst_in = 1'b0, prog_mode_in = 1'b0;
  logic bs1 = 1'b0, bs2 = 1'b0, lv, osc, wr_n, oe_n, rdy;
  fcl_pkg::fcl_ser_req_t ser_in = '0;
  logic [2:0] grp_wr = 3'h0;
  logic [1:0] act;
  logic [7:0] port_v = 8'h00, pd, dq, srd, lock, cal, pins;
  logic [7:0] cal_d = 8'h00, stage = 8'h00;
  logic [3:0] gdat = 4'h0;
  logic cal_wr = 1'b0, doe;
  fcl_pkg::fcl_fuse_t fc;
  int err_count = 0, checked = 0, seed = 71, cyc = 0, hi = 'hDF, lo = 'h62, ext = 'hF9, lck = 'hFF, v;
  int e[4];
  initial forever #12.5 clk_in = ~clk_in;
  fcl_prog_model i_fcl_prog_model (.clk_in, .osc_out(osc), .act_out(act), .wr_n_out(wr_n),
    .oe_n_out(oe_n), .data_out(pd));
  fcl_top #(.BUSY_CYC(4'h2)) i_fcl_top (.clk_in, .nrst_in, .core_rst_in, .prog_mode_in,
    .oscillator_input_pin_in(osc), .action_select_hi_in(act[1]), .action_select_lo_in(act[0]),
    .byte_sel1_in(bs1), .byte_sel2_in(bs2), .wr_n_in(wr_n), .oe_n_in(oe_n), .data_in(pd), .ser_in,
    .osc_calibration_reg_wr_in(cal_wr), .osc_calibration_reg_data_in(cal_d), .grp_cfg_wr_in(grp_wr), .grp_cfg_data_in(gdat),
    .port_val_in(port_v), .stage_drive_in(stage), .data_out(dq), .data_oe_n_out(doe), .rdy_out(rdy),
    .ser_rdata_out(srd), .fuse_cfg_out(fc), .lock_out(lock), .osc_calibration_reg_out(cal),
    .group0_out_a_out(pins[0]), .group0_out_b_out(pins[1]), .group1_out_a_out(pins[2]),
    .group1_out_b_out(pins[3]), .group2_out_a_out(pins[4]), .group2_out_b_out(pins[5]),
    .group2_out_c_out(pins[6]), .group2_out_d_out(pins[7]));
  // ==========
  // Compare, serial access and closing
  task automatic chk(input logic [23:0] x, input logic [23:0] g);
    checked++;
    if (g !== x)
    begin
      err_count++;
      $display("wrong value t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task automatic sr(input logic w, input logic [1:0] s, input logic [7:0] a, input logic [7:0] d);
    ser_in = '{1'b1, w, s, a, d};
    @(posedge clk_in);
    #2;
    ser_in.req = 1'b0;
    @(posedge clk_in);
    #2;
  endtask
  task automatic summarize();
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      summarize();
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_in);
    #2 nrst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    chk({ext[7:0], hi[7:0], lo[7:0]}, fc);
    v = $random(seed);
    #2 {cal_wr, cal_d, port_v} = {1'b1, v[15:0]};
    @(posedge clk_in);
    #2 {cal_wr, core_rst_in} = 2'h1;
    chk(v[15:8], cal);
    repeat (2) @(posedge clk_in);
    #2 core_rst_in = 1'b0;
    chk(8'h80, cal);
    chk(port_v, pins);
    prog_mode_in = 1'b1;
    e = '{lo, hi | 'h20, ext, 'h0};
    for (int i = 0; i < 3; i++)
    begin
      sr(1'b0, i[1:0], 8'h00, 8'h00);
      chk(e[i][7:0], srd);
    end
    e = '{'h5A, 'h42, 'h07, 'h0};
    for (int i = 0; i < 3; i++)
    begin
      sr(1'b0, fcl_pkg::SER_ID, i[7:0], 8'h00);
      chk(e[i][7:0], srd);
    end
    v = $random(seed);
    sr(1'b1, fcl_pkg::SER_HI, 8'h00, v[7:0]);
    hi = (v & 'hDF) | (hi & 'h20);
    repeat (2) @(posedge clk_in);
    chk({8'hF9, 8'hD7 | (v[7:0] & 8'h08), 8'h62}, fc);
    lv = v[9];
    ext = {3'b000, lv, 4'hF};
    sr(1'b1, fcl_pkg::SER_EXT, 8'h00, ext[7:0]);
    i_fcl_prog_model.load(fcl_pkg::ACT_CMD, fcl_pkg::CMD_WR_FUSE);
    i_fcl_prog_model.load(fcl_pkg::ACT_DATA, v[23:16]);
    i_fcl_prog_model.strobe();
    lo = v[23:16];
    i_fcl_prog_model.load(fcl_pkg::ACT_CMD, fcl_pkg::CMD_ERASE);
    i_fcl_prog_model.strobe();
    i_fcl_prog_model.load(fcl_pkg::ACT_CMD, fcl_pkg::CMD_WR_LOCK);
    i_fcl_prog_model.load(fcl_pkg::ACT_DATA, 8'hFE);
    i_fcl_prog_model.strobe();
    repeat (20) if (rdy !== 1'b1) @(posedge clk_in);
    lck = 'hFE;
    sr(1'b1, fcl_pkg::SER_LO, 8'h00, 8'h00);
    sr(1'b0, fcl_pkg::SER_LO, 8'h00, 8'h00);
    chk(lo[7:0], srd);
    i_fcl_prog_model.load(fcl_pkg::ACT_CMD, fcl_pkg::CMD_RD_FUSE);
    e = '{lo, lck, ext, hi};
    for (int i = 0; i < 4; i++)
    begin
      {bs2, bs1} = i[1:0];
      i_fcl_prog_model.oe(1'b0);
      chk({e[i][7:0], 1'b0}, {dq, doe});
    end
    i_fcl_prog_model.oe(1'b1);
    chk(1'b1, doe);
    bs2 = 1'b0;
    bs1 = 1'b0;
    i_fcl_prog_model.load(fcl_pkg::ACT_CMD, fcl_pkg::CMD_RD_ID);
    i_fcl_prog_model.load(fcl_pkg::ACT_ADDR, fcl_pkg::ID_ADDR_SIZE);
    i_fcl_prog_model.oe(1'b0);
    chk(8'h42, dq);
    bs1 = 1'b1;
    i_fcl_prog_model.oe(1'b0);
    chk(8'h80, dq);
    i_fcl_prog_model.oe(1'b1);
    prog_mode_in = 1'b0;
    repeat (3) @(posedge clk_in);
    chk({ext[7:0], hi[7:0], lo[7:0]}, fc);
    #2 core_rst_in = 1'b1;
    port_v = {8{~lv}};
    repeat (3) @(posedge clk_in);
    chk({8{lv}}, pins);
    v = $random(seed);
    #2 {core_rst_in, port_v, stage, gdat} = {1'b0, v[19:0]};
    @(posedge clk_in);
    #2 grp_wr = 3'h7;
    @(posedge clk_in);
    #2 grp_wr = 3'h0;
    repeat (2) @(posedge clk_in);
    v = {gdat, gdat[1:0], gdat[1:0]};
    chk((v[7:0] & stage) | (~v[7:0] & port_v), pins);
    summarize();
  end
endmodule
`default_nettype wire
